// >>> include/acs_pkg.sv
// atm cell screening fifo: shared constants, field layouts and carriers
package acs_pkg;
    // ------------------------------------------------------------
    // cell geometry and storage
    // ------------------------------------------------------------
    localparam int unsigned CELL_BYTES = 53;
    localparam int unsigned HDR_BYTES = 5;
    localparam int unsigned PAY_BYTES = 48;
    localparam int unsigned MEM_DEPTH = 64;
    localparam int unsigned HEC_IDX = 4;
    localparam int unsigned LUT_DEPTH = 16;
    localparam int unsigned LUT_AW = 4;
    localparam int unsigned ACC_CYCLES = 2;
    // ------------------------------------------------------------
    // header check
    // ------------------------------------------------------------
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // five header bytes as they arrive, first byte in the top bits
    typedef struct packed {
        logic [3:0] gfc;
        logic [3:0] vpi_hi;
        logic [3:0] vpi_lo;
        logic [3:0] vci_a;
        logic [7:0] vci_b;
        logic [3:0] vci_c;
        logic [2:0] pti;
        logic clp;
        logic [7:0] hec;
    } acs_hdr_raw_t;

    // decoded header fields
    typedef struct packed {
        logic [3:0] gfc;
        logic [7:0] vpi;
        logic [15:0] vci;
        logic [2:0] pti;
        logic clp;
        logic [7:0] hec;
    } acs_hdr_t;

    // lookup memory load port
    typedef struct packed {
        logic we;
        logic [LUT_AW-1:0] addr;
        logic [7:0] data;
    } acs_lut_wr_t;

    // one crc-8 step over a byte, msb first
    function automatic logic [7:0] acs_crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[7] ^ d[i]) begin
                r = (r << 1) ^ CRC_POLY;
            end else begin
                r = r << 1;
            end
        end
        return r;
    endfunction
endpackage

// >>> verilog/acs_hdr_xlat.sv
// header translator: routing byte lookup and 8-bit pass-through register
`timescale 1ns/10ps
module acs_hdr_xlat
    import acs_pkg::*;
(
    input wire logic clk_i, // core clock
    input wire logic reset_i, // sync, active high
    input wire logic byte_valid_i, // one byte offered this cycle
    input wire logic byte_first_i, // offered byte is header byte one
    input wire logic [7:0] byte_i, // offered byte
    input wire logic egress_i, // 1: restore header, 0: translate
    input wire acs_lut_wr_t lut_wr_i, // lookup memory load
    output logic byte_valid_o, // registered byte ready, one cycle
    output logic [7:0] byte_o, // registered byte
    output logic [11:0] vpi_ext_o // expanded path id
);
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic [7:0] route;
        logic second;
        logic [11:0] vpi_ext;
    } acs_xlat_st_t;

    acs_xlat_st_t x_q, x_d;
    logic [7:0] lut_q [LUT_DEPTH];
    logic [LUT_AW-1:0] lut_addr;
    logic lut_rd;

    // ------------------------------------------------------------
    // lookup memory
    // ------------------------------------------------------------
    // egress addresses by the destination port held in the routing byte
    assign lut_addr = egress_i ? byte_i[7:4] : byte_i[3:0];
    assign lut_rd = byte_valid_i && byte_first_i;

    // one port: a load that collides with a read is dropped
    always_ff @(posedge clk_i) begin
        if (lut_wr_i.we && !lut_rd) begin
            lut_q[lut_wr_i.addr] <= lut_wr_i.data;
        end
    end

    // ------------------------------------------------------------
    // byte pipeline
    // ------------------------------------------------------------
    always_comb begin
        x_d = x_q;
        x_d.valid = byte_valid_i;
        if (byte_valid_i) begin
            x_d.second = byte_first_i;
            if (byte_first_i) begin
                x_d.data = lut_q[lut_addr];
                x_d.route = lut_q[lut_addr];
            end else begin
                x_d.data = byte_i;
            end
            if (x_q.second) begin
                x_d.vpi_ext = {x_q.route, byte_i[7:4]};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            x_q <= '0;
        end else begin
            x_q <= x_d;
        end
    end

    assign byte_valid_o = x_q.valid;
    assign byte_o = x_q.data;
    assign vpi_ext_o = x_q.vpi_ext;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_first_replaced: assert property (@(posedge clk_i) disable iff (reset_i)
        lut_rd |=> byte_o == $past(lut_q[lut_addr]))
        else $error("first byte not replaced by routing byte");
    a_pass_unchanged: assert property (@(posedge clk_i) disable iff (reset_i)
        (byte_valid_i && !byte_first_i) |=> byte_valid_o && byte_o == $past(byte_i))
        else $error("payload byte altered in pipeline");
endmodule

// >>> verilog/acs_cell_screen.sv
// single-cell screening buffer: header crc check, discard, forward
`timescale 1ns/10ps
module acs_cell_screen
    import acs_pkg::*;
#(
    parameter int unsigned DEPTH = MEM_DEPTH
) (
    input wire logic clk_i, // 125 MHz core clock
    input wire logic reset_i, // sync, active high
    input wire logic in_req_i, // source offers a byte
    input wire logic [7:0] in_data_i, // source byte
    output logic in_ack_o, // byte taken
    output logic out_req_o, // byte offered downstream
    output logic [7:0] out_data_o, // downstream byte
    input wire logic out_ack_i, // downstream took the byte
    input wire logic egress_i, // translator restores header
    input wire acs_lut_wr_t lut_wr_i, // lookup memory load
    output acs_hdr_t hdr_o, // fields of the last checked header
    output logic hdr_ok_o, // header passed, one cycle
    output logic hdr_err_o, // header failed, one cycle
    output logic [11:0] vpi_ext_o // expanded path id
);
    localparam int unsigned PW = $clog2(DEPTH);
    localparam logic [PW-1:0] CELL_LEN = PW'(CELL_BYTES);
    localparam logic [PW-1:0] CELL_LAST = PW'(CELL_BYTES - 1);
    localparam logic [PW-1:0] HEC_POS = PW'(HEC_IDX);
    localparam logic [PW-1:0] PTR_ONE = PW'(1);

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_WR = 2'b01,
        PH_RD = 2'b10
    } acs_phase_t;

    typedef struct packed {
        acs_phase_t phase;
        logic [PW-1:0] addr;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW-1:0] in_cnt;
        logic [7:0] wdata;
        logic [7:0] crc;
        acs_hdr_raw_t raw;
        acs_hdr_t hdr;
        logic cell_ok;
        logic drop;
        logic rd_wait;
        logic in_ack;
        logic out_req;
        logic hdr_ok;
        logic hdr_err;
    } acs_state_t;

    acs_state_t s_q, s_d;
    logic [7:0] mem_q [DEPTH];
    logic [7:0] rd_byte;
    acs_hdr_raw_t raw_n;
    logic full;
    logic empty;
    logic wr_req;
    logic rd_req;
    logic x_valid;
    logic [7:0] x_byte;
    logic [11:0] x_vpi;

    // ------------------------------------------------------------
    // status and requests
    // ------------------------------------------------------------
    // one cell fills the store; a dropped cell keeps the counter at zero
    assign full = (s_q.wr_ptr == CELL_LEN);
    assign empty = (s_q.rd_ptr == s_q.wr_ptr);
    // a byte is asked for only once its handshake has started
    assign wr_req = in_req_i && !s_q.in_ack && !full;
    // reads wait for a checked header and an idle downstream handshake
    assign rd_req = s_q.cell_ok && !empty && !s_q.rd_wait
        && !s_q.out_req && !out_ack_i;
    assign raw_n = acs_hdr_raw_t'({s_q.raw[8*HDR_BYTES-9:0], s_q.wdata});

    // ------------------------------------------------------------
    // cell store, one shared address
    // ------------------------------------------------------------
    // the phase decides read or write, so one address port suffices
    always_ff @(posedge clk_i) begin
        if (s_q.phase == PH_WR && !s_q.drop) begin
            mem_q[s_q.addr] <= s_q.wdata;
        end
    end
    assign rd_byte = mem_q[s_q.addr];

    // ------------------------------------------------------------
    // control
    // ------------------------------------------------------------
    // arbitration in idle, the access in the following cycle
    always_comb begin
        s_d = s_q;
        s_d.hdr_ok = 1'b0;
        s_d.hdr_err = 1'b0;
        // four-phase return to zero on both ports
        if (s_q.in_ack && !in_req_i) begin
            s_d.in_ack = 1'b0;
        end
        if (s_q.out_req && out_ack_i) begin
            s_d.out_req = 1'b0;
        end
        if (x_valid) begin
            s_d.out_req = 1'b1;
            s_d.rd_wait = 1'b0;
        end
        unique case (s_q.phase)
            PH_IDLE: begin
                // read wins a tie; an empty store has no read to offer
                if (rd_req && (!wr_req || !empty)) begin
                    s_d.phase = PH_RD;
                    s_d.addr = s_q.rd_ptr;
                    s_d.rd_wait = 1'b1;
                end else if (wr_req) begin
                    s_d.phase = PH_WR;
                    s_d.addr = s_q.wr_ptr;
                    s_d.wdata = in_data_i;
                end
            end
            PH_RD: begin
                s_d.phase = PH_IDLE;
                s_d.rd_ptr = s_q.rd_ptr + PTR_ONE;
                // last byte out frees the store for the next cell
                if (s_q.rd_ptr == CELL_LAST) begin
                    s_d.rd_ptr = '0;
                    s_d.wr_ptr = '0;
                    s_d.cell_ok = 1'b0;
                end
            end
            PH_WR: begin
                s_d.phase = PH_IDLE;
                s_d.in_ack = 1'b1;
                s_d.in_cnt = s_q.in_cnt + PTR_ONE;
                if (!s_q.drop) begin
                    s_d.wr_ptr = s_q.wr_ptr + PTR_ONE;
                end
                if (s_q.in_cnt < HEC_POS) begin
                    s_d.crc = acs_crc8(s_q.crc, s_q.wdata);
                    s_d.raw = raw_n;
                end
                if (s_q.in_cnt == HEC_POS) begin
                    s_d.raw = raw_n;
                    s_d.hdr.gfc = raw_n.gfc;
                    s_d.hdr.vpi = {raw_n.vpi_hi, raw_n.vpi_lo};
                    s_d.hdr.vci = {raw_n.vci_a, raw_n.vci_b, raw_n.vci_c};
                    s_d.hdr.pti = raw_n.pti;
                    s_d.hdr.clp = raw_n.clp;
                    s_d.hdr.hec = raw_n.hec;
                    if (s_q.crc == s_q.wdata) begin
                        s_d.cell_ok = 1'b1;
                        s_d.hdr_ok = 1'b1;
                    end else begin
                        // whole cell gone at once; payload still acked
                        s_d.wr_ptr = '0;
                        s_d.drop = 1'b1;
                        s_d.hdr_err = 1'b1;
                    end
                end
                // the 53rd byte closes the cell on the input side
                if (s_q.in_cnt == CELL_LAST) begin
                    s_d.in_cnt = '0;
                    s_d.drop = 1'b0;
                    s_d.crc = CRC_INIT;
                end
            end
            default: begin
                s_d.phase = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // translator on the forward path
    // ------------------------------------------------------------
    acs_hdr_xlat u_xlat (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .byte_valid_i(s_q.phase == PH_RD),
        .byte_first_i(s_q.addr == '0),
        .byte_i(rd_byte),
        .egress_i(egress_i),
        .lut_wr_i(lut_wr_i),
        .byte_valid_o(x_valid),
        .byte_o(x_byte),
        .vpi_ext_o(x_vpi)
    );

    // outputs straight from flops
    assign in_ack_o = s_q.in_ack;
    assign out_req_o = s_q.out_req;
    assign out_data_o = x_byte;
    assign hdr_o = s_q.hdr;
    assign hdr_ok_o = s_q.hdr_ok;
    assign hdr_err_o = s_q.hdr_err;
    assign vpi_ext_o = x_vpi;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_hec_write;
        s_q.phase == PH_WR && s_q.in_cnt == HEC_POS;
    endsequence
    sequence s_verdict;
        (hdr_ok_o || hdr_err_o) && hdr_o.hec == $past(s_q.wdata);
    endsequence

    a_cell_bound: assert property (s_q.wr_ptr <= CELL_LEN && s_q.in_cnt <= CELL_LAST)
        else $error("cell longer than 53 bytes");
    a_hec_verdict: assert property (s_hec_write |=> s_verdict)
        else $error("no verdict after fifth header byte");
    a_gfc_vpi_field: assert property (hdr_ok_o |-> {hdr_o.gfc, hdr_o.vpi[7:4]} == mem_q[0])
        else $error("flow control or path id from wrong bits");
    a_vci_field: assert property (hdr_ok_o |-> {hdr_o.vpi[3:0], hdr_o.vci[15:12]} == mem_q[1])
        else $error("channel id from wrong bits");
    a_pti_clp_field: assert property (hdr_ok_o |-> {hdr_o.vci[3:0], hdr_o.pti, hdr_o.clp} == mem_q[3])
        else $error("payload type or priority from wrong bits");
    a_crc_match: assert property (hdr_ok_o |-> acs_crc8(acs_crc8(acs_crc8(acs_crc8(CRC_INIT,
        mem_q[0]), mem_q[1]), mem_q[2]), mem_q[3]) == hdr_o.hec)
        else $error("header passed with wrong crc");
    a_bad_discard: assert property (hdr_err_o |-> s_q.wr_ptr == '0 && s_q.drop && !s_q.cell_ok)
        else $error("bad cell not discarded");
    a_read_checked: assert property (s_q.phase == PH_RD |-> s_q.cell_ok)
        else $error("read from an unchecked cell");
    a_two_cycle_acc: assert property (s_q.phase != PH_IDLE |=> s_q.phase == PH_IDLE)
        else $error("access longer than two cycles");
    a_read_first: assert property (s_q.phase == PH_IDLE && rd_req && wr_req |=> s_q.phase == PH_RD)
        else $error("write won over a pending read");
    a_full_no_ack: assert property (full && !s_q.in_ack |=> !in_ack_o)
        else $error("write acked while full");
    a_ack_hold: assert property (in_ack_o && in_req_i |=> in_ack_o)
        else $error("ack dropped before request");
    a_forward_byte: assert property (x_valid |=> out_req_o && !s_q.rd_wait && !x_valid)
        else $error("forwarded byte not offered");
    a_offer_stands: assert property (out_req_o && !out_ack_i |=>
        out_req_o && $stable(out_data_o))
        else $error("offered byte withdrawn before ack");
endmodule

// >>> dv/acs_sink_model.sv
// downstream buffer model: four-phase acknowledge with programmable stall
`timescale 1ns/10ps
module acs_sink_model (
    input wire logic clk_i, // core clock
    input wire logic reset_i, // sync, active high
    input wire logic req_i, // byte offered by the screen
    input wire logic [7:0] data_i, // offered byte
    input wire logic hold_i, // 1: refuse to start a handshake
    input wire logic [3:0] delay_i, // cycles before acknowledging
    output logic ack_o, // byte taken
    output logic got_o, // one cycle: byte captured
    output logic [7:0] got_data_o // captured byte
);
    logic [1:0] st_q;
    logic [3:0] cnt_q;
    // ---------------------------------------------------------
    // handshake sequencer
    // ---------------------------------------------------------
    // ack rises only after req, and falls only after req falls
    always @(posedge clk_i) begin
        got_o <= 1'b0;
        if (reset_i) begin
            ack_o <= 1'b0;
            st_q <= 2'h0;
            cnt_q <= 4'h0;
        end else begin
            case (st_q)
                2'h0: if (req_i === 1'b1 && !hold_i) begin
                    cnt_q <= delay_i;
                    st_q <= 2'h1;
                end
                // data is taken with the ack, while req still holds it
                2'h1: if (cnt_q == 4'h0) begin
                    ack_o <= 1'b1;
                    got_o <= 1'b1;
                    got_data_o <= data_i;
                    st_q <= 2'h2;
                end else begin
                    cnt_q <= cnt_q - 4'h1;
                end
                default: if (req_i === 1'b0) begin
                    ack_o <= 1'b0;
                    st_q <= 2'h0;
                end
            endcase
        end
    end
endmodule

// >>> dv/testbench.sv
// self-checking bench for the cell screening buffer
`timescale 1ns/10ps
module testbench
    import acs_pkg::*;
;
    typedef struct packed {
        logic [31:0] hdr;
        logic bad;
        logic egr;
    } acs_row_t;
    logic clk_i = 1'b0, reset_i = 1'b1, in_req_i = 1'b0, egress_i = 1'b0;
    logic [7:0] in_data_i = 8'h00;
    acs_lut_wr_t lut_wr_i = '0;
    logic in_ack_o, out_req_o, out_ack_i, hdr_ok_o, hdr_err_o, got, hold = 1'b0;
    logic [7:0] out_data_o, got_data;
    logic [3:0] dly = 4'h0;
    logic [11:0] vpi_ext_o;
    acs_hdr_t hdr_o;
    logic [7:0] lut_m [16];
    logic [7:0] got_q[$], exp_q[$];
    int num_errors = 0, cmp_count = 0, n_ok = 0, n_err = 0, cyc = 0;
    // ordinary cases: header bytes one to four, corrupt check byte, egress
    acs_row_t rows [6] = '{'{32'h0123_4560, 1'b0, 1'b0}, '{32'hfa5c_3c01, 1'b0, 1'b1},
        '{32'h0000_0000, 1'b1, 1'b0}, '{32'hffff_fffe, 1'b0, 1'b0},
        '{32'h7e81_0a0b, 1'b1, 1'b1}, '{32'h5a5a_a5a5, 1'b0, 1'b1}};

    acs_cell_screen acs_cell_screen_inst (.clk_i(clk_i), .reset_i(reset_i),
        .in_req_i(in_req_i), .in_data_i(in_data_i), .in_ack_o(in_ack_o),
        .out_req_o(out_req_o), .out_data_o(out_data_o), .out_ack_i(out_ack_i),
        .egress_i(egress_i), .lut_wr_i(lut_wr_i), .hdr_o(hdr_o), .hdr_ok_o(hdr_ok_o),
        .hdr_err_o(hdr_err_o), .vpi_ext_o(vpi_ext_o));
    acs_sink_model acs_sink_model_inst (.clk_i(clk_i), .reset_i(reset_i),
        .req_i(out_req_o), .data_i(out_data_o), .hold_i(hold), .delay_i(dly),
        .ack_o(out_ack_i), .got_o(got), .got_data_o(got_data));

    // ---------------------------------------------------------
    // clock, monitors and hang guard
    // ---------------------------------------------------------
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    // a full run needs well under 10k cycles even with the slowest sink
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (got) got_q.push_back(got_data);
        if (hdr_ok_o === 1'b1) n_ok <= n_ok + 1;
        if (hdr_err_o === 1'b1) n_err <= n_err + 1;
        if (cyc == 30000) begin
            num_errors++;
            close_out();
        end
    end

    // ---------------------------------------------------------
    // compare and drive tasks
    // ---------------------------------------------------------
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic chk_hdr(input acs_hdr_t g, input acs_hdr_t e);
        chk_word(32'(g >> 8), 32'(e >> 8));
        chk_word(32'(g[7:0]), 32'(e[7:0]));
    endtask
    task automatic raise_req(input logic [7:0] b);
        @(negedge clk_i);
        in_req_i = 1'b1;
        in_data_i = b;
    endtask
    // four-phase: hold data until ack, then wait for ack to fall
    task automatic finish_req();
        int n;
        n = 0;
        // a full store drains 53 bytes at seven cycles each before it takes more
        while (in_ack_o !== 1'b1 && n < 1000) begin
            @(negedge clk_i);
            n++;
        end
        chk_word(32'(n < 1000), 32'h1);
        in_req_i = 1'b0;
        in_data_i = ~in_data_i;
        while (in_ack_o !== 1'b0 && n < 2000) begin
            @(negedge clk_i);
            n++;
        end
    endtask
    function automatic logic [7:0] exp_crc(input logic [31:0] h);
        logic [7:0] r;
        r = CRC_INIT;
        for (int i = 31; i >= 0; i--) begin
            r = (r[7] ^ h[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction
    // sends bytes from index first on, expects the whole cell if the check passes
    task automatic send_cell(input acs_row_t r, input int k, input int first);
        logic [7:0] b;
        logic [7:0] lb;
        lb = lut_m[r.egr ? r.hdr[31:28] : r.hdr[27:24]];
        for (int i = 0; i < CELL_BYTES; i++) begin
            b = (i < 4) ? r.hdr[31-8*i -: 8] : (i == 4) ? exp_crc(r.hdr) ^ {7'h0, r.bad}
                : 8'(k * 5 + i);
            if (i >= first) begin
                raise_req(b);
                finish_req();
            end
            if (!r.bad) exp_q.push_back(i == 0 ? lb : b);
        end
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (got_q.size() < exp_q.size() && n < 3000) begin
            @(negedge clk_i);
            n++;
        end
        repeat (20) @(negedge clk_i);
        while (exp_q.size() > 0 && got_q.size() > 0) begin
            chk_word(32'(got_q.pop_front()), 32'(exp_q.pop_front()));
        end
        chk_word(32'(got_q.size() + exp_q.size()), 32'h0);
    endtask
    task automatic close_out();
        $display("comparisons %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ---------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------
    initial begin
        int ok0, er0;
        acs_hdr_t eh;
        logic [3:0] li;
        repeat (10) @(negedge clk_i);
        reset_i = 1'b0;
        chk_word({in_ack_o, out_req_o, hdr_ok_o, hdr_err_o, out_data_o, vpi_ext_o}, 0);
        chk_hdr(hdr_o, '0);
        for (int i = 0; i < 16; i++) begin
            lut_m[i] = 8'(i * 37 + 5);
            lut_wr_i = '{we: 1'b1, addr: 4'(i), data: lut_m[i]};
            @(negedge clk_i);
        end
        lut_wr_i = '0;
        foreach (rows[k]) begin
            ok0 = n_ok;
            er0 = n_err;
            egress_i = rows[k].egr;
            dly = 4'(k * 2);
            send_cell(rows[k], k, 0);
            repeat (4) @(negedge clk_i);
            chk_word(32'(n_ok - ok0), 32'(!rows[k].bad));
            chk_word(32'(n_err - er0), 32'(rows[k].bad));
            eh.gfc = rows[k].hdr[31:28];
            eh.vpi = rows[k].hdr[27:20];
            eh.vci = rows[k].hdr[19:4];
            eh.pti = rows[k].hdr[3:1];
            eh.clp = rows[k].hdr[0];
            eh.hec = exp_crc(rows[k].hdr) ^ {7'h0, rows[k].bad};
            chk_hdr(hdr_o, eh);
            drain();
            if (!rows[k].bad) begin
                // the routing byte comes from whichever nibble the mode uses as address
                li = rows[k].egr ? rows[k].hdr[31:28] : rows[k].hdr[27:24];
                chk_word(32'(vpi_ext_o), 32'({lut_m[li], rows[k].hdr[23:20]}));
            end
        end
        // stalled sink: a full store must refuse the next cell's first byte
        egress_i = 1'b0;
        dly = 4'h0;
        hold = 1'b1;
        send_cell(rows[0], 9, 0);
        raise_req(rows[3].hdr[31:24]);
        ok0 = 0;
        repeat (20) begin
            @(negedge clk_i);
            if (in_ack_o !== 1'b0) ok0++;
        end
        chk_word(32'(ok0), 32'h0);
        hold = 1'b0;
        finish_req();
        send_cell(rows[3], 10, 1);
        drain();
        close_out();
    end
endmodule
